/* File: hw/irq_regs_pkg.sv */
// Purpose: shared constants for the interrupt enable and flag block
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are register indices on the port address

package irq_regs_pkg;

  localparam logic [7:0] ADDR_TIMER_FLAGS = 8'h38;
  localparam logic [7:0] ADDR_TIMER_ENABLES = 8'h39;
  localparam logic [7:0] ADDR_GEN_FLAGS = 8'h3a;
  localparam logic [7:0] ADDR_GEN_ENABLES = 8'h3b;
  localparam logic [7:0] ADDR_MCU_CONTROL = 8'h35;
  localparam logic [7:0] ADDR_CPU_FLAGS = 8'h3f;

  // general enable / flag fields
  localparam int EXT_BIT = 6;
  localparam int PCUP_BIT = 5;
  localparam int PCLO_BIT = 4;
  localparam int PCF_BIT = 5;
  // timer enable / flag fields
  localparam int CMPA_BIT = 6;
  localparam int CMPB_BIT = 5;
  localparam int T1OVF_BIT = 2;
  localparam int T0OVF_BIT = 1;
  // sense select field and global bit
  localparam int SENSE_LO_BIT = 0;
  localparam int SENSE_HI_BIT = 1;
  localparam int GLOBAL_BIT = 7;

  localparam logic [7:0] GEN_EN_MASK = 8'h70;
  localparam logic [7:0] GEN_FLAG_MASK = 8'h60;
  localparam logic [7:0] TMR_MASK = 8'h66;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_EXT = 4'h1;
  localparam logic [3:0] VEC_PINCHG = 4'h2;
  localparam logic [3:0] VEC_CMPA = 4'h3;
  localparam logic [3:0] VEC_CMPB = 4'h4;
  localparam logic [3:0] VEC_T1OVF = 4'h5;
  localparam logic [3:0] VEC_T0OVF = 4'h6;

endpackage : irq_regs_pkg

/* File: hw/pin_sync.sv */
// Purpose: two-stage synchroniser for a bus of pins
// Assumes: pins are asynchronous to ref_clk
// Notes: first stage feeds only the second

`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic [WIDTH-1:0] pin_in, // raw pins
  output logic [WIDTH-1:0] pin_out // synchronised pins
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= '0;
      pin_out <= '0;
    end
    else
    begin
      stage1 <= pin_in;
      pin_out <= stage1;
    end
  end

endmodule : pin_sync

/* File: hw/irq_arbiter.sv */
// Purpose: fixed priority pick among pending interrupt requests
// Assumes: request bit 0 is the lowest vector
// Notes: purely combinational

`timescale 1ns/1ps

module irq_arbiter
  import irq_regs_pkg::*;
(
  input wire logic [5:0] req, // pending requests, bit 0 = vector 1
  output logic [3:0] vec // chosen vector, zero if none
);

  always_comb
  begin
    vec = VEC_NONE;
    for (int i = 5; i >= 0; i--)
    begin
      if (req[i])
      begin
        vec = 4'(i + 1);
      end
    end
  end

endmodule : irq_arbiter

/* File: hw/irq_mask_flag_regs.sv */
// Purpose: interrupt enable and flag registers with vectored request
// Assumes: timer events are one-cycle pulses on ref_clk; pins are async
// Notes: core acknowledges with irq_ack beside the taken vector

`timescale 1ns/1ps

// Functional notes
// - reserved bits of the four registers always read zero
// - external request needs its enable and the global bit
// - sense select picks rising, falling, any change or low level
// - pin activity counts even when the pin is an output
// - external request uses vector 1
// - upper enable covers port B 7..4, port A 7, 6 and 3
// - lower enable covers port B 3..0
// - pins with alternate function never set the pin-change flag
// - both pin-change groups share vector 2
// - external flag sets on a sensed pin event
// - external and pin-change flags clear on vectoring or written one
// - external flag held clear under low-level sensing
// - disabled pin-change group cannot set the flag
// - pin-change flag fed by port B 7..0 and port A 7, 6, 3
// - compare A uses its enable, global bit, vector 3
// - compare B uses its enable, global bit, vector 4
// - timer 1 overflow uses its enable, global bit, vector 5
// - timer 0 overflow uses its enable, global bit, vector 6
// - compare flags set on timer 1 compare matches
// - compare flags clear on vectoring or one cycle after written one
// - compare request needs global bit, enable and flag
// - timer 1 overflow flag set, cleared like compare flags
// - timer 0 overflow flag clears at once on written one
// - lower vector wins among pending requests
module irq_mask_flag_regs
  import irq_regs_pkg::*;
(
  input wire logic ref_clk, // system clock, 200 MHz
  input wire logic reset, // async reset, active high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic ext_pin, // external interrupt pin level
  input wire logic [7:0] port_b_pins, // port B pin levels
  input wire logic [2:0] port_a_pins, // port A bits 7, 6, 3 as [2:0]
  input wire logic [10:0] alt_func_active, // {pa7,pa6,pa3,pb7..pb0} masks
  input wire logic cmp_a_match, // timer 1 compare A pulse
  input wire logic cmp_b_match, // timer 1 compare B pulse
  input wire logic t1_overflow, // timer 1 overflow pulse
  input wire logic t0_overflow, // timer 0 overflow pulse
  input wire logic irq_ack, // core vectored, pulse
  input wire logic [3:0] irq_ack_vec, // vector being taken
  output logic irq_req, // request to core
  output logic [3:0] irq_vec // vector of request
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] gen_en, gen_flags, tmr_en, tmr_flags, pend_clr;
  logic [1:0] sense_sel;
  logic global_en;
  logic [3:0] next_vec;
  logic [5:0] req;

  // ----------------------------------------------------------------
  // pin synchronisation and event detection
  // ----------------------------------------------------------------
  logic [11:0] pins_s, pins_d;
  logic ext_s;
  logic [10:0] pc_s;

  pin_sync #(.WIDTH(12)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in({ext_pin, port_a_pins, port_b_pins}),
    .pin_out(pins_s)
  );

  // pins are read whatever their direction, so software can drive them
  assign ext_s = pins_s[11];
  assign pc_s = pins_s[10:0];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pins_d <= '0;
    end
    else
    begin
      pins_d <= pins_s;
    end
  end

  logic ext_event, ext_rise, ext_fall, pc_event;
  logic [10:0] pc_change, pc_group_en;
  assign ext_rise = ext_s & ~pins_d[11];
  assign ext_fall = ~ext_s & pins_d[11];

  always_comb
  begin
    case (sense_sel)
      SENSE_ANY: ext_event = ext_rise | ext_fall;
      SENSE_FALL: ext_event = ext_fall;
      SENSE_RISE: ext_event = ext_rise;
      default: ext_event = 1'b0;
    endcase
  end

  assign pc_change = pc_s ^ pins_d[10:0];
  // group enables mask the flag itself, not only the request
  assign pc_group_en = {{7{gen_en[PCUP_BIT]}}, {4{gen_en[PCLO_BIT]}}};
  assign pc_event = |(pc_change & pc_group_en & ~alt_func_active);

  logic ack_ext, ack_pc;
  logic [7:0] ack_tmr;
  assign ack_ext = irq_ack && irq_ack_vec == VEC_EXT;
  assign ack_pc = irq_ack && irq_ack_vec == VEC_PINCHG;

  always_comb
  begin
    ack_tmr = 8'h00;
    ack_tmr[CMPA_BIT] = irq_ack && irq_ack_vec == VEC_CMPA;
    ack_tmr[CMPB_BIT] = irq_ack && irq_ack_vec == VEC_CMPB;
    ack_tmr[T1OVF_BIT] = irq_ack && irq_ack_vec == VEC_T1OVF;
    ack_tmr[T0OVF_BIT] = irq_ack && irq_ack_vec == VEC_T0OVF;
  end

  logic wr_gen_en, wr_gen_flags, wr_tmr_en, wr_tmr_flags;
  assign wr_gen_en = reg_wr && reg_addr == ADDR_GEN_ENABLES;
  assign wr_gen_flags = reg_wr && reg_addr == ADDR_GEN_FLAGS;
  assign wr_tmr_en = reg_wr && reg_addr == ADDR_TIMER_ENABLES;
  assign wr_tmr_flags = reg_wr && reg_addr == ADDR_TIMER_FLAGS;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      gen_en <= REG_RESET;
      tmr_en <= REG_RESET;
      sense_sel <= SENSE_LOW;
      global_en <= 1'b0;
    end
    else
    begin
      if (wr_gen_en)
      begin
        gen_en <= reg_wdata & GEN_EN_MASK;
      end
      if (wr_tmr_en)
      begin
        tmr_en <= reg_wdata & TMR_MASK;
      end
      if (reg_wr && reg_addr == ADDR_MCU_CONTROL)
      begin
        sense_sel <= reg_wdata[SENSE_HI_BIT:SENSE_LO_BIT];
      end
      // core clears the global bit on entry; software may set it again
      if (reg_wr && reg_addr == ADDR_CPU_FLAGS)
      begin
        global_en <= reg_wdata[GLOBAL_BIT];
      end
      else if (irq_ack)
      begin
        global_en <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // general flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      gen_flags <= REG_RESET;
    end
    else
    begin
      // set wins over clear in the same cycle
      if (sense_sel == SENSE_LOW)
      begin
        gen_flags[EXT_BIT] <= 1'b0;
      end
      else if (ext_event)
      begin
        gen_flags[EXT_BIT] <= 1'b1;
      end
      else if (ack_ext || (wr_gen_flags && reg_wdata[EXT_BIT]))
      begin
        gen_flags[EXT_BIT] <= 1'b0;
      end
      if (pc_event)
      begin
        gen_flags[PCF_BIT] <= 1'b1;
      end
      else if (ack_pc || (wr_gen_flags && reg_wdata[PCF_BIT]))
      begin
        gen_flags[PCF_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer flags
  // ----------------------------------------------------------------
  logic [7:0] tmr_set;
  always_comb
  begin
    tmr_set = 8'h00;
    tmr_set[CMPA_BIT] = cmp_a_match;
    tmr_set[CMPB_BIT] = cmp_b_match;
    tmr_set[T1OVF_BIT] = t1_overflow;
    tmr_set[T0OVF_BIT] = t0_overflow;
  end

  // written ones for compare and timer 1 flags pass a sync stage first
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pend_clr <= REG_RESET;
    end
    else
    begin
      pend_clr <= wr_tmr_flags ? (reg_wdata & TMR_MASK & ~(8'h01 << T0OVF_BIT)) : REG_RESET;
    end
  end

  logic [7:0] tmr_clr;
  always_comb
  begin
    tmr_clr = pend_clr | ack_tmr;
    tmr_clr[T0OVF_BIT] = ack_tmr[T0OVF_BIT] | (wr_tmr_flags & reg_wdata[T0OVF_BIT]);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tmr_flags <= REG_RESET;
    end
    else
    begin
      tmr_flags <= (tmr_set | (tmr_flags & ~tmr_clr)) & TMR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // request generation
  // ----------------------------------------------------------------
  always_comb
  begin
    req = '0;
    req[0] = global_en & gen_en[EXT_BIT] & (gen_flags[EXT_BIT] | (sense_sel == SENSE_LOW & ~ext_s));
    req[1] = global_en & (gen_en[PCUP_BIT] | gen_en[PCLO_BIT]) & gen_flags[PCF_BIT];
    req[2] = global_en & tmr_en[CMPA_BIT] & tmr_flags[CMPA_BIT];
    req[3] = global_en & tmr_en[CMPB_BIT] & tmr_flags[CMPB_BIT];
    req[4] = global_en & tmr_en[T1OVF_BIT] & tmr_flags[T1OVF_BIT];
    req[5] = global_en & tmr_en[T0OVF_BIT] & tmr_flags[T0OVF_BIT];
  end

  irq_arbiter u_arb (
    .req(req),
    .vec(next_vec)
  );

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_req <= 1'b0;
      irq_vec <= VEC_NONE;
    end
    else
    begin
      // dropped during ack so the core never sees a stale vector
      irq_req <= (next_vec != VEC_NONE) && !irq_ack;
      irq_vec <= irq_ack ? VEC_NONE : next_vec;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_GEN_ENABLES: reg_rdata <= gen_en & GEN_EN_MASK;
        ADDR_GEN_FLAGS: reg_rdata <= gen_flags & GEN_FLAG_MASK;
        ADDR_TIMER_ENABLES: reg_rdata <= tmr_en & TMR_MASK;
        ADDR_TIMER_FLAGS: reg_rdata <= tmr_flags & TMR_MASK;
        ADDR_MCU_CONTROL: reg_rdata <= {6'h00, sense_sel};
        ADDR_CPU_FLAGS: reg_rdata <= {global_en, 7'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset)
    $past(reg_rd) |-> ((reg_rdata & ~GEN_EN_MASK) == 8'h00 || $past(reg_addr) != ADDR_GEN_ENABLES);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
  property p_low_clear;
    @(posedge ref_clk) disable iff (reset)
    (sense_sel == SENSE_LOW) |=> !gen_flags[EXT_BIT];
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("ext flag set in low mode");
  property p_ext_set;
    @(posedge ref_clk) disable iff (reset)
    (ext_event && sense_sel != SENSE_LOW) |=> gen_flags[EXT_BIT];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext flag not set");
  // group split taken from the raw pin order, independent of the enable vector
  property p_pc_masked;
    @(posedge ref_clk) disable iff (reset)
    (!gen_flags[PCF_BIT] && (!gen_en[PCUP_BIT] || pc_s[10:4] == pins_d[10:4])
      && (!gen_en[PCLO_BIT] || pc_s[3:0] == pins_d[3:0])) |=> !gen_flags[PCF_BIT];
  endproperty
  a_pc_masked: assert property (p_pc_masked) else $error("pin-change flag set by masked pin");
  property p_cmp_set;
    @(posedge ref_clk) disable iff (reset)
    cmp_a_match |=> tmr_flags[CMPA_BIT];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare A flag not set");
  // a clear already in flight from an earlier write lands one cycle sooner
  property p_cmp_clr_delay;
    @(posedge ref_clk) disable iff (reset)
    (wr_tmr_flags && reg_wdata[CMPA_BIT] && tmr_flags[CMPA_BIT] && !pend_clr[CMPA_BIT] && !irq_ack)
      ##1 (!cmp_a_match && !irq_ack) |-> tmr_flags[CMPA_BIT] ##1 (!tmr_flags[CMPA_BIT] || $past(cmp_a_match));
  endproperty
  a_cmp_clr_delay: assert property (p_cmp_clr_delay) else $error("compare A clear timing wrong");
  property p_t0_clr;
    @(posedge ref_clk) disable iff (reset)
    (wr_tmr_flags && reg_wdata[T0OVF_BIT] && !t0_overflow) |=> !tmr_flags[T0OVF_BIT];
  endproperty
  a_t0_clr: assert property (p_t0_clr) else $error("timer 0 flag not cleared");
  property p_req_global;
    @(posedge ref_clk) disable iff (reset)
    irq_req |-> $past(global_en);
  endproperty
  a_req_global: assert property (p_req_global) else $error("request without global bit");
  property p_priority;
    @(posedge ref_clk) disable iff (reset)
    ($past(req[0]) && !$past(irq_ack)) |-> irq_vec == VEC_EXT;
  endproperty
  a_priority: assert property (p_priority) else $error("external not given priority");

endmodule : irq_mask_flag_regs

/* File: test/core_model.sv */
// Purpose: behavioural processor core that vectors on the block's request
// Assumes: one vectoring pulse per request, after ack_wait idle cycles
// Notes: ack vector bus shows the inverse of its last value when idle

`timescale 1ns/1ps

module core_model (
  input wire logic ref_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic ack_en, // core accepts requests
  input wire logic [3:0] ack_wait, // cycles before vectoring
  input wire logic irq_req, // request from block
  input wire logic [3:0] irq_vec, // vector of request
  output logic irq_ack, // vectoring pulse
  output logic [3:0] irq_ack_vec, // vector taken
  output logic [3:0] taken_vec // last vector taken
);
  logic [3:0] wait_cnt;

  // never ack twice: the request only drops the cycle after the pulse
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_ack <= 1'b0;
      irq_ack_vec <= 4'h0;
      taken_vec <= 4'h0;
      wait_cnt <= 4'h0;
    end
    else if (irq_ack)
    begin
      irq_ack <= 1'b0;
      irq_ack_vec <= ~irq_ack_vec;
      wait_cnt <= 4'h0;
    end
    else if (ack_en && irq_req)
    begin
      if (wait_cnt == ack_wait)
      begin
        irq_ack <= 1'b1;
        irq_ack_vec <= irq_vec;
        taken_vec <= irq_vec;
      end
      else
      begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
    else
    begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : core_model

/* File: test/tb.sv */
// Purpose: register level tests of the interrupt enable and flag block
// Assumes: core_model vectors the requests
// Notes: pin events are given several cycles to pass the synchroniser

`timescale 1ns/1ps

module tb;
  import irq_regs_pkg::*;
  logic ref_clk, reset, reg_wr, reg_rd, ext_pin, ack_en, irq_ack, irq_req;
  logic cmp_a_match, cmp_b_match, t1_overflow, t0_overflow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_b_pins;
  logic [2:0] port_a_pins;
  logic [10:0] alt_func_active;
  logic [3:0] ack_wait, irq_ack_vec, irq_vec, taken_vec;
  int num_errors, checks, cyc;

  irq_mask_flag_regs i_irq_mask_flag_regs (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .port_b_pins(port_b_pins), .port_a_pins(port_a_pins), .alt_func_active(alt_func_active),
    .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match), .t1_overflow(t1_overflow),
    .t0_overflow(t0_overflow), .irq_ack(irq_ack), .irq_ack_vec(irq_ack_vec), .irq_req(irq_req),
    .irq_vec(irq_vec));
  core_model i_core_model (.ref_clk(ref_clk), .reset(reset), .ack_en(ack_en), .ack_wait(ack_wait),
    .irq_req(irq_req), .irq_vec(irq_vec), .irq_ack(irq_ack), .irq_ack_vec(irq_ack_vec),
    .taken_vec(taken_vec));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp, "register read");
  endtask : chk_reg

  task automatic chk_req(input logic r, input logic [3:0] v);
    #1;
    cmp({3'h0, irq_req, irq_vec}, {3'h0, r, v}, "request");
  endtask : chk_req

  task automatic chk_taken(input logic [3:0] v);
    cmp({4'h0, taken_vec}, {4'h0, v}, "vector taken");
  endtask : chk_taken

  task automatic tmr(input logic [3:0] p);
    @(posedge ref_clk);
    {cmp_a_match, cmp_b_match, t1_overflow, t0_overflow} <= p;
    @(posedge ref_clk);
    {cmp_a_match, cmp_b_match, t1_overflow, t0_overflow} <= 4'h0;
    tick(3);
  endtask : tmr

  task automatic pin(input logic v);
    @(posedge ref_clk);
    ext_pin <= v;
    tick(6);
  endtask : pin

  task automatic toggle(input int i);
    @(posedge ref_clk);
    {port_a_pins, port_b_pins} <= {port_a_pins, port_b_pins} ^ (11'h1 << i);
    tick(6);
  endtask : toggle

  // hang guard, far above the several hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      end_sim();
    end
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial
  begin
    logic [7:0] addrs [6];
    addrs = '{ADDR_TIMER_FLAGS, ADDR_TIMER_ENABLES, ADDR_GEN_FLAGS, ADDR_GEN_ENABLES, ADDR_MCU_CONTROL,
      ADDR_CPU_FLAGS};
    {reg_wr, reg_rd, reg_addr, reg_wdata, ack_en, ack_wait} = '0;
    {cmp_a_match, cmp_b_match, t1_overflow, t0_overflow, alt_func_active, port_a_pins, port_b_pins} = '0;
    ext_pin = 1'b1;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    reset = 1'b1;
    tick(8);
    reset <= 1'b0;
    foreach (addrs[k]) chk_reg(addrs[k], REG_RESET);
    chk_reg(8'h00, 8'h00);
    wr(ADDR_GEN_ENABLES, 8'hff);
    chk_reg(ADDR_GEN_ENABLES, GEN_EN_MASK);
    wr(ADDR_TIMER_ENABLES, 8'hff);
    chk_reg(ADDR_TIMER_ENABLES, TMR_MASK);
    wr(ADDR_GEN_FLAGS, 8'hff);
    chk_reg(ADDR_GEN_FLAGS, 8'h00);
    wr(ADDR_GEN_ENABLES, 8'h00);
    wr(ADDR_TIMER_ENABLES, 8'h00);
    // timer flags, masking by the global bit, vectoring in order
    tmr(4'hf);
    chk_reg(ADDR_TIMER_FLAGS, TMR_MASK);
    wr(ADDR_TIMER_FLAGS, 8'h99);
    chk_reg(ADDR_TIMER_FLAGS, TMR_MASK);
    wr(ADDR_TIMER_ENABLES, TMR_MASK);
    tick(3);
    chk_req(1'b0, VEC_NONE);
    ack_en <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ack_wait <= 4'(k);
      wr(ADDR_CPU_FLAGS, 8'h80);
      tick(10);
      chk_taken(VEC_CMPA + 4'(k));
      chk_reg(ADDR_CPU_FLAGS, 8'h00);
    end
    chk_reg(ADDR_TIMER_FLAGS, 8'h00);
    tmr(4'hf);
    wr(ADDR_TIMER_FLAGS, TMR_MASK);
    tick(2);
    chk_reg(ADDR_TIMER_FLAGS, 8'h00);
    wr(ADDR_TIMER_ENABLES, 8'h00);
    // external pin sense modes, flag only
    for (int m = 1; m < 4; m++)
    begin
      wr(ADDR_MCU_CONTROL, 8'(m));
      pin(1'b0);
      chk_reg(ADDR_GEN_FLAGS, (2'(m) != SENSE_RISE) ? 8'h40 : 8'h00);
      wr(ADDR_GEN_FLAGS, 8'h40);
      pin(1'b1);
      chk_reg(ADDR_GEN_FLAGS, (2'(m) != SENSE_FALL) ? 8'h40 : 8'h00);
      wr(ADDR_GEN_FLAGS, 8'h40);
      chk_reg(ADDR_GEN_FLAGS, 8'h00);
    end
    // low level sensing: no flag, request only while low
    ack_en <= 1'b0;
    wr(ADDR_GEN_ENABLES, 8'h40);
    wr(ADDR_MCU_CONTROL, 8'h00);
    pin(1'b0);
    chk_reg(ADDR_GEN_FLAGS, 8'h00);
    chk_req(1'b0, VEC_NONE);
    wr(ADDR_CPU_FLAGS, 8'h80);
    tick(2);
    chk_req(1'b1, VEC_EXT);
    pin(1'b1);
    chk_req(1'b0, VEC_NONE);
    wr(ADDR_CPU_FLAGS, 8'h00);
    wr(ADDR_MCU_CONTROL, 8'(SENSE_RISE));
    // pin change groups, every pin in the wrong and the right group
    for (int i = 0; i < 11; i++)
    begin
      wr(ADDR_GEN_ENABLES, (i < 4) ? 8'h20 : 8'h10);
      toggle(i);
      chk_reg(ADDR_GEN_FLAGS, 8'h00);
      wr(ADDR_GEN_ENABLES, (i < 4) ? 8'h10 : 8'h20);
      toggle(i);
      chk_reg(ADDR_GEN_FLAGS, 8'h20);
      wr(ADDR_GEN_FLAGS, 8'h20);
    end
    wr(ADDR_GEN_ENABLES, 8'h30);
    @(posedge ref_clk) alt_func_active <= 11'h020;
    toggle(5);
    chk_reg(ADDR_GEN_FLAGS, 8'h00);
    @(posedge ref_clk) alt_func_active <= 11'h000;
    toggle(2);
    ack_en <= 1'b1;
    wr(ADDR_CPU_FLAGS, 8'h80);
    tick(8);
    chk_taken(VEC_PINCHG);
    chk_reg(ADDR_GEN_FLAGS, 8'h00);
    // two sources pending at once: lower vector first
    wr(ADDR_GEN_ENABLES, 8'h40);
    wr(ADDR_TIMER_ENABLES, 8'h40);
    tmr(4'h8);
    pin(1'b0);
    pin(1'b1);
    ack_wait <= 4'h3;
    wr(ADDR_CPU_FLAGS, 8'h80);
    tick(10);
    chk_taken(VEC_EXT);
    wr(ADDR_CPU_FLAGS, 8'h80);
    tick(10);
    chk_taken(VEC_CMPA);
    chk_reg(ADDR_TIMER_FLAGS, 8'h00);
    end_sim();
  end
endmodule : tb
